/* File: src/knc_consts.vh */
// constants for the knock limit and output control block
`ifndef KNC_CONSTS_VH
`define KNC_CONSTS_VH
`define KNC_NCH        18
`define KNC_LAST_CH    5'h11
`define KNC_GAIN_DEF   9'h064
`define KNC_GAIN_MAX   9'h12c
`define KNC_GAIN_RECIP 7'h29
`define KNC_GAIN_SHIFT 12
`define KNC_CLK_NS     100
`define KNC_TICK_CYC4  4'ha
`define KNC_TICK_CYC2  4'h5
`define KNC_RAMP_LAST  10'h3e7
`define KNC_RATE_SHIFT 4
`define KNC_ANA_FS     12'hfff
`define KNC_DISP_MIN   2'h0
`define KNC_DISP_MAX   2'h1
`define KNC_DISP_POS   2'h2
`define KNC_ENG_INLINE 2'h0
`define KNC_ENG_VTYPE  2'h1
`define KNC_ENG_IRREG  2'h2
`define KNC_ST_IDLE    2'h0
`define KNC_ST_DELAY   2'h1
`define KNC_ST_OPEN    2'h2
`define KNC_ST_EVAL    2'h3
`endif

/* File: src/knc_gain_scale.v */
// per-channel gain scaler, gain of 100 passes the level unchanged
`timescale 1ns/1ps
`include "knc_consts.vh"
module knc_gain_scale (
  // raw level and gain
  input  wire [7:0] i_level,
  input  wire [8:0] i_gain,
  // scaled level, saturated
  output wire [7:0] o_level
);
  wire [23:0] prod;
  wire [11:0] quot;

  // multiply by reciprocal instead of dividing by 100, exact for 8-bit levels at gain 100
  assign prod    = i_level * i_gain * `KNC_GAIN_RECIP;
  assign quot    = prod[23:`KNC_GAIN_SHIFT];
  assign o_level = (quot > 12'h0ff) ? 8'hff : quot[7:0];
endmodule

/* File: src/knc_top.v */
// knock limit decision, timing-retard output and trip control
`timescale 1ns/1ps
`include "knc_consts.vh"
module knc_top (
  // clock and reset
  input  wire        I_CLK,
  input  wire        I_RST,
  // engine timing and front end
  input  wire        I_SYNC,
  input  wire        I_LOAD_RED,
  input  wire [7:0]  I_CH_LEVEL,
  input  wire        I_CH_BAD,
  input  wire        I_CH_NOSIG,
  // engine configuration
  input  wire [1:0]  I_ENG_TYPE,
  input  wire        I_STROKE4,
  input  wire [4:0]  I_CYL_CNT,
  input  wire [7:0]  I_V_ANGLE,
  input  wire [15:0] I_WIN_DELAY,
  input  wire [15:0] I_WIN_WIDTH,
  // gain and firing sequence writes
  input  wire        I_GAIN_WE,
  input  wire [4:0]  I_GAIN_CH,
  input  wire [8:0]  I_GAIN_VAL,
  input  wire        I_SEQ_WE,
  input  wire [4:0]  I_SEQ_POS,
  input  wire [4:0]  I_SEQ_CYL,
  // output options
  input  wire [7:0]  I_RETARD_LIM,
  input  wire [7:0]  I_STOP_LIM,
  input  wire [11:0] I_DEC_RAMP,
  input  wire [7:0]  I_RET_GAIN,
  input  wire [11:0] I_MAX_OUT,
  input  wire        I_MAX_EN,
  input  wire [15:0] I_LR_DELAY,
  input  wire        I_INVERT,
  input  wire        I_LATCH_EN,
  input  wire        I_BAD_EN,
  input  wire        I_TRIP_POL,
  // display and diagnostics
  input  wire [1:0]  I_DISP_MODE,
  input  wire [4:0]  I_DISP_POS,
  input  wire [17:0] I_DISP_EN,
  input  wire        I_DIAG,
  input  wire        I_DIAG_KNOCK,
  input  wire        I_DIAG_TRIP,
  input  wire [11:0] I_DIAG_ANALOG,
  // outputs
  output reg         O_WINDOW,
  output reg  [4:0]  O_CH_SEL,
  output reg         O_KNOCK,
  output reg         O_KNOCK_LED,
  output reg         O_TRIP_CONTACT,
  output reg         O_EXHAUSTED,
  output reg         O_BAD_SENSOR,
  output reg  [17:0] O_BAD_MAP,
  output reg  [11:0] O_ANALOG,
  output reg  [7:0]  O_DISP_VAL,
  output reg  [4:0]  O_DISP_CYL
);
  reg  [8:0]  gain_q [0:`KNC_NCH-1];
  reg  [4:0]  seq_q  [0:`KNC_NCH-1];
  reg  [7:0]  int_q  [0:`KNC_NCH-1];
  reg  [17:0] over_r_q;
  reg  [17:0] over_s_q;
  reg  [17:0] bad_q;
  reg  [1:0]  eng_q;
  reg  [4:0]  cyl_cnt_q;
  reg  [1:0]  st_q;
  reg  [15:0] cnt_q;
  reg  [4:0]  pos_q;
  reg         sync_q;
  reg  [3:0]  div_q;
  reg  [9:0]  ramp_div_q;
  reg         tick;
  reg         ramp_en;
  reg  [11:0] retard_q;
  reg  [15:0] lr_cnt_q;
  reg         knock_prev_q;
  reg         latch_en_q;
  wire [7:0]  scaled;
  wire        knock_any;
  wire        stop_any;
  wire        trip;
  reg  [17:0] act;
  reg  [7:0]  mn;
  reg  [7:0]  mx;
  reg  [4:0]  mn_c;
  reg  [4:0]  mx_c;
  reg  [7:0]  kmax;
  reg  [12:0] up_sum;
  reg  [12:0] raw_d;
  reg  [11:0] retard_d;
  reg  [3:0]  tick_cyc;
  reg  [15:0] rate_p;
  integer     i;
  integer     gi;
  integer     si;

  // cylinder at a firing position for the current engine type
  function [4:0] cyl_at;
    input [4:0] pos;
    begin
      case (eng_q)
        `KNC_ENG_IRREG: cyl_at = seq_q[pos];
        `KNC_ENG_VTYPE: cyl_at = pos[0] ? ((cyl_cnt_q >> 1) + (pos >> 1)) : (pos >> 1);
        default:        cyl_at = pos;
      endcase
    end
  endfunction

  knc_gain_scale u_scale (
    .i_level (I_CH_LEVEL),
    .i_gain  (gain_q[O_CH_SEL]),
    .o_level (scaled)
  );

  // microsecond tick; a 2-stroke cycle is half as long so counts run twice as fast
  always @* begin
    tick_cyc = I_STROKE4 ? `KNC_TICK_CYC4 : `KNC_TICK_CYC2;
  end

  always @(posedge I_CLK) begin
    if (I_RST) begin
      div_q      <= 4'h0;
      tick       <= 1'b0;
      ramp_div_q <= 10'h000;
      ramp_en    <= 1'b0;
    end else begin
      tick    <= (div_q == tick_cyc - 4'h1);
      div_q   <= (div_q == tick_cyc - 4'h1) ? 4'h0 : div_q + 4'h1;
      ramp_en <= tick && (ramp_div_q == `KNC_RAMP_LAST);
      if (tick) begin
        ramp_div_q <= (ramp_div_q == `KNC_RAMP_LAST) ? 10'h000 : ramp_div_q + 10'h001;
      end
    end
  end

  // gain and firing sequence tables, written any time
  always @(posedge I_CLK) begin
    if (I_RST) begin
      for (gi = 0; gi < `KNC_NCH; gi = gi + 1) begin
        gain_q[gi] <= `KNC_GAIN_DEF;
        seq_q[gi]  <= gi[4:0];
      end
    end else begin
      if (I_GAIN_WE && I_GAIN_CH <= `KNC_LAST_CH) begin
        gain_q[I_GAIN_CH] <= (I_GAIN_VAL > `KNC_GAIN_MAX) ? `KNC_GAIN_MAX : I_GAIN_VAL;
      end
      if (I_SEQ_WE && I_SEQ_POS <= `KNC_LAST_CH) begin
        seq_q[I_SEQ_POS] <= I_SEQ_CYL;
      end
    end
  end

  // window sequencer: one cylinder per sync pulse, engine type and cylinder count taken at start of each cycle
  always @(posedge I_CLK) begin
    if (I_RST) begin
      st_q      <= `KNC_ST_IDLE;
      cnt_q     <= 16'h0000;
      pos_q     <= 5'h00;
      sync_q    <= 1'b0;
      eng_q     <= `KNC_ENG_INLINE;
      cyl_cnt_q <= 5'h01;
      O_WINDOW  <= 1'b0;
      O_CH_SEL  <= 5'h00;
      over_r_q  <= 18'h00000;
      over_s_q  <= 18'h00000;
      bad_q     <= 18'h00000;
      for (si = 0; si < `KNC_NCH; si = si + 1) begin
        int_q[si] <= 8'h00;
      end
    end else begin
      sync_q <= I_SYNC;
      case (st_q)
        `KNC_ST_IDLE: begin
          if (I_SYNC && !sync_q) begin
            if (pos_q == 5'h00) begin
              eng_q     <= I_ENG_TYPE;
              cyl_cnt_q <= (I_CYL_CNT == 5'h00 || I_CYL_CNT > `KNC_LAST_CH + 5'h01) ?
                           `KNC_LAST_CH + 5'h01 : I_CYL_CNT;
            end
            // second bank of a V engine fires later by the bank angle
            cnt_q    <= (eng_q == `KNC_ENG_VTYPE && pos_q[0]) ?
                        I_WIN_DELAY + {8'h00, I_V_ANGLE} : I_WIN_DELAY;
            O_CH_SEL <= cyl_at(pos_q);
            st_q     <= `KNC_ST_DELAY;
          end
        end
        `KNC_ST_DELAY: begin
          if (tick) begin
            if (cnt_q == 16'h0000) begin
              O_WINDOW <= 1'b1;
              cnt_q    <= I_WIN_WIDTH;
              st_q     <= `KNC_ST_OPEN;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
        end
        `KNC_ST_OPEN: begin
          if (tick) begin
            if (cnt_q == 16'h0000) begin
              O_WINDOW <= 1'b0;
              st_q     <= `KNC_ST_EVAL;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
        end
        `KNC_ST_EVAL: begin
          // front end holds the window peak on its level input through this sample, just after the window closes
          int_q[O_CH_SEL]    <= scaled;
          over_r_q[O_CH_SEL] <= scaled > I_RETARD_LIM;
          over_s_q[O_CH_SEL] <= scaled > I_STOP_LIM;
          bad_q[O_CH_SEL]    <= I_BAD_EN && I_CH_BAD && !I_CH_NOSIG;
          pos_q <= (pos_q + 5'h01 >= cyl_cnt_q) ? 5'h00 : pos_q + 5'h01;
          st_q  <= `KNC_ST_IDLE;
        end
        default: st_q <= `KNC_ST_IDLE;
      endcase
    end
  end

  // scan of all cylinders: monitoring uses every active one, display only the masked ones
  always @* begin
    act  = 18'h00000;
    mn   = 8'hff;
    mx   = 8'h00;
    mn_c = 5'h00;
    mx_c = 5'h00;
    kmax = 8'h00;
    for (i = 0; i < `KNC_NCH; i = i + 1) begin
      act[i] = (i < cyl_cnt_q);
      if (act[i] && int_q[i] > kmax) begin
        kmax = int_q[i];
      end
      if (act[i] && I_DISP_EN[i]) begin
        if (int_q[i] <= mn) begin
          mn   = int_q[i];
          mn_c = i[4:0];
        end
        if (int_q[i] >= mx) begin
          mx   = int_q[i];
          mx_c = i[4:0];
        end
      end
    end
  end

  assign knock_any = |(over_r_q & act);
  assign stop_any  = |(over_s_q & act);
  assign trip      = stop_any | (|(bad_q & act)) | O_EXHAUSTED;

  // retard integrator: up by gain times intensity, down by the ramp after any hold
  always @* begin
    rate_p = I_RET_GAIN * kmax;
    up_sum = {1'b0, retard_q} + {1'b0, rate_p[15:`KNC_RATE_SHIFT]};
    if (knock_any) begin
      raw_d = up_sum;
    end else if (lr_cnt_q != 16'h0000) begin
      raw_d = {1'b0, retard_q};
    end else if (retard_q > I_DEC_RAMP) begin
      raw_d = {1'b0, retard_q - I_DEC_RAMP};
    end else begin
      raw_d = 13'h0000;
    end
    if (I_MAX_EN && raw_d > {1'b0, I_MAX_OUT}) begin
      retard_d = I_MAX_OUT;
    end else if (raw_d[12]) begin
      retard_d = `KNC_ANA_FS;
    end else begin
      retard_d = raw_d[11:0];
    end
  end

  // load-reduction hold, armed when knocking ends while load is being shed
  always @(posedge I_CLK) begin
    if (I_RST) begin
      knock_prev_q <= 1'b0;
      lr_cnt_q     <= 16'h0000;
    end else begin
      knock_prev_q <= knock_any;
      if (knock_prev_q && !knock_any && I_LOAD_RED) begin
        lr_cnt_q <= I_LR_DELAY;
      end else if (knock_any) begin
        lr_cnt_q <= 16'h0000;
      end else if (ramp_en && lr_cnt_q != 16'h0000) begin
        lr_cnt_q <= lr_cnt_q - 16'h0001;
      end
    end
  end

  // retard value and exhausted status move once per ramp tick
  always @(posedge I_CLK) begin
    if (I_RST) begin
      retard_q    <= 12'h000;
      O_EXHAUSTED <= 1'b0;
    end else if (ramp_en) begin
      retard_q    <= retard_d;
      O_EXHAUSTED <= raw_d > {1'b0, I_MAX_OUT};
    end
  end

  // binary outputs, indicator latch and diagnostics override
  always @(posedge I_CLK) begin
    if (I_RST) begin
      latch_en_q     <= 1'b0;
      O_KNOCK        <= 1'b0;
      O_KNOCK_LED    <= 1'b0;
      O_TRIP_CONTACT <= 1'b0;
      O_BAD_SENSOR   <= 1'b0;
      O_BAD_MAP      <= 18'h00000;
    end else begin
      latch_en_q <= I_LATCH_EN;
      // knocking wins over the off-on clear so a fresh event is never lost
      O_KNOCK_LED  <= knock_any | (I_LATCH_EN & O_KNOCK_LED & latch_en_q);
      O_KNOCK      <= I_DIAG ? I_DIAG_KNOCK : knock_any;
      // polarity high inverts the contact so it is closed in normal running
      O_TRIP_CONTACT <= (I_DIAG ? I_DIAG_TRIP : trip) ^ I_TRIP_POL;
      O_BAD_SENSOR   <= |(bad_q & act);
      O_BAD_MAP      <= bad_q & act;
    end
  end

  // analog value and display value
  always @(posedge I_CLK) begin
    if (I_RST) begin
      O_ANALOG   <= 12'h000;
      O_DISP_VAL <= 8'h00;
      O_DISP_CYL <= 5'h00;
    end else begin
      if (I_DIAG) begin
        O_ANALOG <= I_DIAG_ANALOG;
      end else begin
        O_ANALOG <= I_INVERT ? `KNC_ANA_FS - retard_q : retard_q;
      end
      case (I_DISP_MODE)
        `KNC_DISP_MIN: begin
          O_DISP_VAL <= mn;
          O_DISP_CYL <= mn_c;
        end
        `KNC_DISP_MAX: begin
          O_DISP_VAL <= mx;
          O_DISP_CYL <= mx_c;
        end
        `KNC_DISP_POS: begin
          // position is 1-based in firing order
          O_DISP_CYL <= cyl_at(I_DISP_POS - 5'h01);
          O_DISP_VAL <= int_q[cyl_at(I_DISP_POS - 5'h01)];
        end
        default: begin
          O_DISP_VAL <= 8'h00;
          O_DISP_CYL <= 5'h00;
        end
      endcase
    end
  end
endmodule

/* File: verif/knc_front_model.sv */
// sync source and sensor front end facing the knock block
`timescale 1ns/1ps
module knc_front_model (
  // clock and bench control
  input  wire       i_clk,
  input  wire       i_fire,
  input  wire [7:0] i_level,
  // block side
  input  wire       i_window,
  output reg        o_sync,
  output wire [7:0] o_level
);
  reg [1:0] hold_q;
  // sync follows a fire request; peak held through the sample edge
  always @(posedge i_clk) begin
    o_sync <= i_fire;
    hold_q <= i_window ? 2'h3 : {1'b0, hold_q[1]};
  end
  // outside the hold show junk so a late sample cannot pass by luck
  assign o_level = (i_window || hold_q != 2'h0) ? i_level : ~i_level;
endmodule

/* File: verif/knc_top_monitor.sv */
// concurrent checks on the knock limit block ports
`timescale 1ns/1ps
module knc_top_monitor (
  // clock and reset
  input wire        I_CLK,
  input wire        I_RST,
  // watched inputs
  input wire        I_DIAG,
  input wire        I_DIAG_KNOCK,
  input wire [11:0] I_DIAG_ANALOG,
  input wire        I_TRIP_POL,
  input wire        I_LATCH_EN,
  input wire        I_STROKE4,
  input wire [15:0] I_WIN_WIDTH,
  // watched outputs
  input wire        O_WINDOW,
  input wire [4:0]  O_CH_SEL,
  input wire        O_KNOCK,
  input wire        O_KNOCK_LED,
  input wire        O_TRIP_CONTACT,
  input wire        O_EXHAUSTED,
  input wire        O_BAD_SENSOR,
  input wire [17:0] O_BAD_MAP,
  input wire [11:0] O_ANALOG
);
  reg  [19:0] wlen_q;
  wire [19:0] wlen_exp;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // cycles the window has stood open
  always @(posedge I_CLK) begin
    if (I_RST || !O_WINDOW) wlen_q <= 20'h0;
    else wlen_q <= wlen_q + 20'h1;
  end
  // 2-stroke ticks take half the clocks
  assign wlen_exp = ({4'h0, I_WIN_WIDTH} + 20'h1) * (I_STROKE4 ? 20'ha : 20'h5);
  // override settled long enough for any output latency
  sequence diag_held;
    (I_DIAG && $stable(I_DIAG_ANALOG) && $stable(I_DIAG_KNOCK)) [*3];
  endsequence
  a_diag_analog: assert property (diag_held |=> O_ANALOG == $past(I_DIAG_ANALOG))
    else $error("diag analog not passed");
  a_diag_knock: assert property (diag_held |=> O_KNOCK == $past(I_DIAG_KNOCK))
    else $error("diag knock not passed");
  a_win_len: assert property ($fell(O_WINDOW) |-> wlen_q == wlen_exp)
    else $error("window length wrong");
  a_sel_range: assert property (O_CH_SEL <= 5'h11)
    else $error("channel select out of range");
  a_led_knock: assert property (O_KNOCK && !I_DIAG && !$past(I_DIAG) |-> O_KNOCK_LED)
    else $error("indicator dark while knocking");
  a_latch_off: assert property (!I_LATCH_EN && !$past(I_LATCH_EN) && !O_KNOCK && !I_DIAG && !$past(I_DIAG)
    |-> !O_KNOCK_LED) else $error("indicator held without latch");
  a_trip_pol: assert property ($changed(I_TRIP_POL) && !I_DIAG |=> $changed(O_TRIP_CONTACT))
    else $error("polarity did not flip contact");
  a_bad_map: assert property (O_BAD_SENSOR |-> O_BAD_MAP != 18'h0)
    else $error("fault flag without channel");
  a_bad_trip: assert property ($rose(O_BAD_SENSOR) && !I_DIAG |-> ##[0:1] (O_TRIP_CONTACT != I_TRIP_POL))
    else $error("sensor fault without trip");
  a_exh_trip: assert property (O_EXHAUSTED && !I_DIAG |-> ##[0:2] (O_TRIP_CONTACT != I_TRIP_POL))
    else $error("exhausted without trip");
endmodule
bind knc_top knc_top_monitor u_mon (.I_CLK(I_CLK), .I_RST(I_RST), .I_DIAG(I_DIAG), .I_DIAG_KNOCK(I_DIAG_KNOCK),
  .I_DIAG_ANALOG(I_DIAG_ANALOG), .I_TRIP_POL(I_TRIP_POL), .I_LATCH_EN(I_LATCH_EN), .I_STROKE4(I_STROKE4),
  .I_WIN_WIDTH(I_WIN_WIDTH), .O_WINDOW(O_WINDOW), .O_CH_SEL(O_CH_SEL), .O_KNOCK(O_KNOCK),
  .O_KNOCK_LED(O_KNOCK_LED), .O_TRIP_CONTACT(O_TRIP_CONTACT), .O_EXHAUSTED(O_EXHAUSTED),
  .O_BAD_SENSOR(O_BAD_SENSOR), .O_BAD_MAP(O_BAD_MAP), .O_ANALOG(O_ANALOG));

/* File: verif/knc_top_tb.sv */
// self-checking bench for the knock limit block
`timescale 1ns/1ps
`include "knc_consts.vh"
module knc_top_tb;
  reg        clk = 1'b0, rst = 1'b1, fire = 1'b0, lred = 1'b0, s4 = 1'b1, gwe = 1'b0, maxen = 1'b0;
  reg        inv = 1'b0, len = 1'b0, baden = 1'b0, pol = 1'b0, diag = 1'b0, dknk = 1'b0, dtrip = 1'b0;
  reg        cbad = 1'b0, nosig = 1'b0, swe = 1'b0;
  reg [1:0]  eng = `KNC_ENG_INLINE, dmode = `KNC_DISP_MAX;
  reg [4:0]  cyl = 5'h01, gch = 5'h00, spos = 5'h00, scyl = 5'h00, dpos = 5'h01;
  reg [8:0]  gval = `KNC_GAIN_DEF;
  reg [7:0]  lvl = 8'h00, rlim = 8'h78, slim = 8'hf0, rgain = 8'h10, vang = 8'h00;
  reg [11:0] dramp = 12'hfff, maxo = 12'hfff, dana = 12'h000;
  reg [15:0] wdly = 16'h0001, wwid = 16'h0001, lrd = 16'h0000;
  reg [17:0] den = 18'h3ffff;
  wire       sync, win, knock, led, trip, exh, bad;
  wire [7:0] mlvl, dval;
  wire [4:0] sel, dcyl;
  wire [17:0] bmap;
  wire [11:0] ana;
  integer    n_mismatch = 0, total_checks = 0, cyc = 0, k, kw;
  knc_front_model u_fe (.i_clk(clk), .i_fire(fire), .i_level(lvl), .i_window(win), .o_sync(sync), .o_level(mlvl));
  knc_top u_dut (.I_CLK(clk), .I_RST(rst), .I_SYNC(sync), .I_LOAD_RED(lred), .I_CH_LEVEL(mlvl),
    .I_CH_BAD(cbad), .I_CH_NOSIG(nosig), .I_ENG_TYPE(eng), .I_STROKE4(s4), .I_CYL_CNT(cyl),
    .I_V_ANGLE(vang), .I_WIN_DELAY(wdly), .I_WIN_WIDTH(wwid), .I_GAIN_WE(gwe), .I_GAIN_CH(gch),
    .I_GAIN_VAL(gval), .I_SEQ_WE(swe), .I_SEQ_POS(spos), .I_SEQ_CYL(scyl), .I_RETARD_LIM(rlim),
    .I_STOP_LIM(slim), .I_DEC_RAMP(dramp), .I_RET_GAIN(rgain), .I_MAX_OUT(maxo), .I_MAX_EN(maxen),
    .I_LR_DELAY(lrd), .I_INVERT(inv), .I_LATCH_EN(len), .I_BAD_EN(baden), .I_TRIP_POL(pol),
    .I_DISP_MODE(dmode), .I_DISP_POS(dpos), .I_DISP_EN(den), .I_DIAG(diag), .I_DIAG_KNOCK(dknk),
    .I_DIAG_TRIP(dtrip), .I_DIAG_ANALOG(dana), .O_WINDOW(win), .O_CH_SEL(sel), .O_KNOCK(knock),
    .O_KNOCK_LED(led), .O_TRIP_CONTACT(trip), .O_EXHAUSTED(exh), .O_BAD_SENSOR(bad), .O_BAD_MAP(bmap),
    .O_ANALOG(ana), .O_DISP_VAL(dval), .O_DISP_CYL(dcyl));
  // 10 MHz clock
  initial forever #50 clk = ~clk;
  // hang guard, a few ms of ramp ticks at most
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task print_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [17:0] got, input [17:0] exp, input [8*9-1:0] nm);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      $display("[FAIL] %0s exp %h seen %h", nm, exp, got);
      n_mismatch = n_mismatch + 1;
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task gain_wr(input [8:0] v);
    gval <= v;
    gwe <= 1'b1;
    step(1);
    gwe <= 1'b0;
  endtask
  // trailing edge keeps back-to-back writes from touching the strobe twice in one step
  task seq_wr(input [4:0] p, input [4:0] c);
    spos <= p;
    scyl <= c;
    swe <= 1'b1;
    step(1);
    swe <= 1'b0;
    step(1);
  endtask
  // one sync, wait the window through, then let decisions land
  task win_run(input [7:0] l);
    lvl <= l;
    fire <= 1'b1;
    step(1);
    fire <= 1'b0;
    k = 0;
    while (win !== 1'b1 && k < 400) begin step(1); k = k + 1; end
    kw = k;
    while (win !== 1'b0 && k < 800) begin step(1); k = k + 1; end
    chk(k < 800, 1'b1, "window");
    step(4);
  endtask
  task t_diag;
    diag <= 1'b1;
    dknk <= 1'b1;
    dtrip <= 1'b1;
    dana <= 12'h5a5;
    step(5);
    chk({knock, trip, ana}, 14'h35a5, "diag_out");
    diag <= 1'b0;
    dknk <= 1'b0;
    dtrip <= 1'b0;
    step(3);
    chk({knock, trip, ana}, 14'h0000, "diag_off");
  endtask
  task t_gain;
    gain_wr(9'h032);
    win_run(8'hc8);
    chk(knock, 1'b0, "g50_knk");
    chk(dval, 8'h64, "disp_max");
    den <= 18'h3fffe;
    gain_wr(9'h1ff);
    win_run(8'h30);
    chk(knock, 1'b1, "g300_knk");
    den <= 18'h3ffff;
    gain_wr(`KNC_GAIN_DEF);
    dmode <= `KNC_DISP_MIN;
    step(3);
    chk(dval, 8'h90, "disp_min");
    dmode <= `KNC_DISP_POS;
    step(3);
    chk({dcyl, dval}, 13'h0090, "disp_pos");
  endtask
  // rise 0x10*0x90>>4 per ms, clamp, then ramp off
  task t_retard;
    k = 0;
    while (ana === 12'h000 && k < 12000) begin step(1); k = k + 1; end
    chk(ana, 12'h090, "ret_rise");
    maxen <= 1'b1;
    maxo <= 12'h0a0;
    k = 0;
    while (exh !== 1'b1 && k < 12000) begin step(1); k = k + 1; end
    step(3);
    chk(ana, 12'h0a0, "ret_clamp");
    chk(trip, 1'b1, "exh_trip");
    // knock ends during load shedding: one ramp of hold, then steps of 0x50
    lred <= 1'b1;
    lrd <= 16'h0001;
    dramp <= 12'h050;
    win_run(8'h10);
    lred <= 1'b0;
    k = 0;
    while (exh !== 1'b0 && k < 12000) begin step(1); k = k + 1; end
    step(3);
    chk(ana, 12'h0a0, "lr_hold");
    k = 0;
    while (ana === 12'h0a0 && k < 12000) begin step(1); k = k + 1; end
    chk(ana, 12'h050, "ret_dec");
    k = 0;
    while (ana !== 12'h000 && k < 12000) begin step(1); k = k + 1; end
    chk({knock, ana}, 13'h0000, "ret_fall");
    maxen <= 1'b0;
    maxo <= 12'hfff;
  endtask
  task t_bad;
    baden <= 1'b1;
    cbad <= 1'b1;
    nosig <= 1'b1;
    win_run(8'h10);
    chk({bad, trip}, 2'h0, "nosig");
    nosig <= 1'b0;
    win_run(8'h10);
    chk(bmap, 18'h00001, "bad_map");
    chk({bad, trip}, 2'h3, "bad_trip");
    cbad <= 1'b0;
    win_run(8'h10);
    chk(bad, 1'b0, "bad_clr");
    inv <= 1'b1;
    step(3);
    chk(ana, 12'hfff, "inv_zero");
    inv <= 1'b0;
  endtask
  task t_stop;
    win_run(8'hf8);
    chk({knock, trip}, 2'h3, "stop_trip");
    pol <= 1'b1;
    step(3);
    chk(trip, 1'b0, "pol_close");
    pol <= 1'b0;
    step(3);
  endtask
  task t_latch;
    len <= 1'b1;
    step(2);
    win_run(8'h10);
    chk({knock, led}, 2'h1, "led_hold");
    len <= 1'b0;
    step(2);
    len <= 1'b1;
    step(3);
    chk(led, 1'b0, "led_clr");
  endtask
  // V bank order and angle in 2-stroke, then a user firing table
  task t_fire;
    eng <= `KNC_ENG_VTYPE;
    cyl <= 5'h04;
    vang <= 8'h10;
    s4 <= 1'b0;
    win_run(8'h10);
    win_run(8'h10);
    chk(sel, 5'h02, "v_sel");
    chk(kw > 60, 1'b1, "v_angle");
    win_run(8'h10);
    chk(sel, 5'h01, "v_sel2");
    seq_wr(5'h00, 5'h01);
    seq_wr(5'h01, 5'h00);
    eng <= `KNC_ENG_IRREG;
    cyl <= 5'h02;
    win_run(8'h10);
    win_run(8'h10);
    win_run(8'h10);
    chk(sel, 5'h00, "irr_pos1");
    win_run(8'hc8);
    chk({knock, sel}, 6'h21, "irr_pos0");
    chk({dcyl, dval}, 13'h01c8, "disp_irr");
    dpos <= 5'h02;
    step(3);
    chk({dcyl, dval}, 13'h0010, "disp_irr2");
  endtask
  // main sequence
  initial begin
    step(12);
    rst <= 1'b0;
    step(2);
    chk({win, knock, led, trip, exh, bad, ana}, 18'h0, "rst_out");
    t_diag;
    t_gain;
    t_retard;
    t_bad;
    t_stop;
    t_latch;
    t_fire;
    print_verdict;
  end
endmodule
